/* File: hdl/brc_reset_ctrl.sv */
// Reset sequencer and domain control for the bridge reset controller.
// Summary of operation
// - Hold power-on reset until core supply sense reports 90 percent of nominal.
// - Release power-on reset 10 us after reference clock activity is seen.
// - Power-on reset clears every register, state machine, sticky and PM state except the edge trackers and latched straps.
// - Any hardware reset source asserts the secondary bus reset output.
// - Low global reset forces power-on reset asynchronously, without a clock.
// - While global reset is low all domains are held at defaults.
// - Rising global reset samples static configuration inputs once and holds them.
// - After global or fundamental reset release, start EEPROM download and link setup.
// - Link training starts within 80 ms of global reset release.
// - Link training starts within 80 ms of fundamental reset release.
// - Low fundamental reset applies link reset and clears non-sticky bits.
// - Low fundamental reset resets machines except sticky and aux PM ones.
// - Rising fundamental reset is taken as system power good.
// - Rising fundamental reset samples and latches static configuration inputs.
// - Hot reset on the link moves the link interface into data-link-down.
// - Data-link-down resets all but sticky, EEPROM-loadable, EEPROM and aux PM.
`default_nettype none
module brc_reset_ctrl #(
	parameter int TRAIN_CYC = brc_pkg::TRAIN_DELAY_CYC
) (
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_in,
	input  wire logic                        global_reset_n_in,
	input  wire logic                        fund_reset_n_in,
	input  wire logic                        core_supply_sense_in,
	input  wire logic                        refclk_active_in,
	input  wire logic                        hot_reset_in,
	input  wire logic                        eeprom_present_in,
	input  wire logic [brc_pkg::STRAP_W-1:0] strap_in,
	input  wire brc_pkg::brc_cfg_req_t       cfg_req_in,
	output logic [15:0]                      cfg_rdata_out,
	output logic                             secondary_bus_reset_n_out,
	output logic                             link_reset_out,
	output logic                             data_link_down_out,
	output logic                             power_good_out,
	output logic                             eeprom_load_start_out,
	output logic                             link_train_start_out,
	output brc_pkg::brc_domains_t            domain_reset_out,
	output logic [brc_pkg::STRAP_W-1:0]      strap_out
);
	// Global reset acts without the clock: it clears the power-on domain asynchronously.
	logic        global_reset_n_q1;
	logic        global_reset_n_q2;
	always_ff @(posedge clk_sys_in or negedge global_reset_n_in) begin
		if (!global_reset_n_in) begin
			global_reset_n_q1 <= 1'b0;
			global_reset_n_q2 <= 1'b0;
		end else begin
			global_reset_n_q1 <= 1'b1;
			global_reset_n_q2 <= global_reset_n_q1;
		end
	end

	// Two-stage synchronisers for the supply, clock activity, fundamental and hot reset pins.
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       supply_ok;
	logic       refclk_ok;
	logic       perst_n;
	logic       hot_rst;
	assign supply_ok = sync2[0];
	assign refclk_ok = sync2[1];
	assign perst_n   = sync2[2];
	assign hot_rst   = sync2[3];
	always_ff @(posedge clk_sys_in) begin
		sync1 <= {hot_reset_in, fund_reset_n_in, refclk_active_in, core_supply_sense_in};
		sync2 <= sync1;
	end

	// Strap pins are static but still cross in through two stages before capture.
	logic [brc_pkg::STRAP_W-1:0] strap_s1;
	logic [brc_pkg::STRAP_W-1:0] strap_s2;
	always_ff @(posedge clk_sys_in) begin
		strap_s1 <= strap_in;
		strap_s2 <= strap_s1;
	end

	// Power-on sequencing state.
	brc_pkg::brc_state_t     state;
	brc_pkg::brc_state_t     next_state;
	logic [brc_pkg::CNT_W-1:0] clk_cnt;
	logic [brc_pkg::CNT_W-1:0] next_clk_cnt;
	logic                    por;
	always_comb begin
		next_state   = state;
		next_clk_cnt = clk_cnt;
		case (state)
			brc_pkg::BRC_POWER: begin
				next_clk_cnt = '0;
				if (supply_ok) begin
					next_state = brc_pkg::BRC_CLKWT;
				end
			end
			brc_pkg::BRC_CLKWT: begin
				if (!supply_ok) begin
					next_state = brc_pkg::BRC_POWER;
				// The wait starts at the first sign of clock activity and then runs on its own.
				end else if (refclk_ok || clk_cnt != '0) begin
					next_clk_cnt = clk_cnt + 1'b1;
					if (clk_cnt == brc_pkg::CNT_W'(brc_pkg::REFCLK_WAIT_CYC - 1)) begin
						next_state = brc_pkg::BRC_RUN;
					end
				end
			end
			brc_pkg::BRC_RUN: begin
				next_clk_cnt = '0;
				if (!supply_ok) begin
					next_state = brc_pkg::BRC_POWER;
				end
			end
			default: begin
				next_state   = brc_pkg::BRC_POWER;
				next_clk_cnt = '0;
			end
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge global_reset_n_in) begin
		if (!global_reset_n_in) begin
			state   <= brc_pkg::BRC_POWER;
			clk_cnt <= '0;
		end else if (rst_in) begin
			state   <= brc_pkg::BRC_POWER;
			clk_cnt <= '0;
		end else begin
			state   <= next_state;
			clk_cnt <= next_clk_cnt;
		end
	end
	// Internal power-on reset covers sequencing and the global reset pin.
	assign por = (state != brc_pkg::BRC_RUN) || !global_reset_n_q2;

	// Edge tracking, link state, strap capture and start sequencing.
	logic        global_reset_n_prev;
	logic        perst_prev;
	logic        next_global_reset_n_prev;
	logic        next_perst_prev;
	logic        global_reset_n_rise;
	logic        perst_rise;
	logic        dl_down;
	logic        next_dl_down;
	logic [brc_pkg::STRAP_W-1:0] strap;
	logic [brc_pkg::STRAP_W-1:0] next_strap;
	logic        pwr_good;
	logic        next_pwr_good;
	logic        train_pend;
	logic        next_train_pend;
	logic [brc_pkg::CNT_W-1:0] train_cnt;
	logic [brc_pkg::CNT_W-1:0] next_train_cnt;
	logic        ee_start;
	logic        next_ee_start;
	logic        train_start;
	logic        next_train_start;
	logic [15:0] ctl;
	logic [15:0] next_ctl;
	logic [15:0] rdata;
	logic [15:0] next_rdata;
	logic        sec_n;
	logic        next_sec_n;
	logic        boot;
	logic        next_boot;
	brc_pkg::brc_domains_t dom;
	brc_pkg::brc_domains_t next_dom;

	assign global_reset_n_rise  = global_reset_n_q2 && !global_reset_n_prev;
	// The fundamental reset edge detector tracks its pin through power-on reset.
	assign perst_rise = perst_n && !perst_prev && !por;

	always_comb begin
		next_global_reset_n_prev   = global_reset_n_q2;
		next_perst_prev  = perst_n;
		next_dl_down     = dl_down;
		next_strap       = strap;
		next_pwr_good    = pwr_good;
		next_train_pend  = train_pend;
		next_train_cnt   = train_cnt;
		next_ee_start    = 1'b0;
		next_train_start = 1'b0;
		next_ctl         = ctl;
		next_rdata       = rdata;
		next_boot        = 1'b0;
		// Hot reset wins over the retrain pulse, so a held hot reset keeps the link down.
		if (hot_rst) begin
			next_dl_down = 1'b1;
		end else if (train_start) begin
			next_dl_down = 1'b0;
		end
		// Straps move only on a real rising edge, never on a quiet release of power-on reset.
		if (global_reset_n_rise || perst_rise) begin
			next_strap = strap_s2;
		end
		// Power good follows a rising fundamental reset and drops while it is low.
		if (!perst_n) begin
			next_pwr_good = 1'b0;
		end else if (perst_rise) begin
			next_pwr_good = 1'b1;
		end
		// Release of global or fundamental reset launches download and a bounded wait before training; leaving link-down launches only the wait.
		if (por || !perst_n) begin
			next_train_pend = 1'b0;
			next_train_cnt  = '0;
		end else if (boot || perst_rise || (!train_pend && dl_down && !hot_rst)) begin
			// The first cycle after power-on reset stands for the global reset release.
			next_ee_start   = eeprom_present_in && (boot || perst_rise);
			next_train_pend = 1'b1;
			next_train_cnt  = '0;
		end else if (train_pend) begin
			next_train_cnt = train_cnt + 1'b1;
			if (train_cnt == brc_pkg::CNT_W'(TRAIN_CYC - 1)) begin
				next_train_pend  = 1'b0;
				next_train_start = 1'b1;
			end
		end
		// Ordinary bits clear on every reset source, including data-link-down.
		if (por || !perst_n || dl_down) begin
			next_ctl = brc_pkg::SEC_BUS_CTL_RESET;
		end else if (cfg_req_in.wr && cfg_req_in.addr == brc_pkg::SEC_BUS_CTL_OFFSET) begin
			next_ctl = cfg_req_in.wdata;
		end
		// Reads of any other offset return zero.
		if (cfg_req_in.rd && cfg_req_in.addr == brc_pkg::SEC_BUS_CTL_OFFSET) begin
			next_rdata = ctl;
		end else if (cfg_req_in.rd) begin
			next_rdata = 16'h0000;
		end
		// Active low, so the pin level comes straight from this register.
		next_sec_n = !(por || !perst_n || dl_down || hot_rst ||
			ctl[brc_pkg::SEC_RESET_BIT]);
		// Sticky and aux power management clear only on power-on reset.
		next_dom.sticky   = por;
		next_dom.aux_pm   = por;
		next_dom.eeprom   = por || !perst_n;
		next_dom.ordinary = por || !perst_n || dl_down;

		// Power-on reset forces every domain to its default; edges and straps still track.
		if (por) begin
			next_dl_down     = 1'b0;
			next_pwr_good    = 1'b0;
			next_train_pend  = 1'b0;
			next_train_cnt   = '0;
			next_ee_start    = 1'b0;
			next_train_start = 1'b0;
			next_ctl         = brc_pkg::SEC_BUS_CTL_RESET;
			next_rdata       = 16'h0000;
			next_sec_n       = 1'b0;
			next_dom         = '1;
			next_boot        = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		// Power-on reset is folded into the next values; only the sync reset acts here.
		if (rst_in) begin
			global_reset_n_prev   <= 1'b0;
			perst_prev  <= 1'b0;
			dl_down     <= 1'b0;
			strap       <= brc_pkg::STRAP_RESET;
			pwr_good    <= 1'b0;
			train_pend  <= 1'b0;
			train_cnt   <= '0;
			ee_start    <= 1'b0;
			train_start <= 1'b0;
			ctl         <= brc_pkg::SEC_BUS_CTL_RESET;
			rdata       <= 16'h0000;
			sec_n       <= 1'b0;
			dom         <= '1;
			boot        <= 1'b1;
		end else begin
			global_reset_n_prev   <= next_global_reset_n_prev;
			perst_prev  <= next_perst_prev;
			dl_down     <= next_dl_down;
			strap       <= next_strap;
			pwr_good    <= next_pwr_good;
			train_pend  <= next_train_pend;
			train_cnt   <= next_train_cnt;
			ee_start    <= next_ee_start;
			train_start <= next_train_start;
			ctl         <= next_ctl;
			rdata       <= next_rdata;
			sec_n       <= next_sec_n;
			dom         <= next_dom;
			boot        <= next_boot;
		end
	end

	assign cfg_rdata_out             = rdata;
	assign secondary_bus_reset_n_out = sec_n;
	assign link_reset_out            = dom.eeprom;
	assign data_link_down_out        = dl_down;
	assign power_good_out            = pwr_good;
	assign eeprom_load_start_out     = ee_start;
	assign link_train_start_out      = train_start;
	assign domain_reset_out          = dom;
	assign strap_out                 = strap;
endmodule
`default_nettype wire

/* File: hdl/brc_pkg.sv */
// Package of constants and types for the bridge reset controller.
`default_nettype none
package brc_pkg;
	localparam logic [7:0]  SEC_BUS_CTL_OFFSET = 8'h3e;
	localparam int          SEC_RESET_BIT      = 6;
	localparam logic [15:0] SEC_BUS_CTL_RESET  = 16'h0000;
	localparam int          CLK_PERIOD_PS      = 5000;
	localparam int          REFCLK_WAIT_NS     = 10000;
	localparam int          REFCLK_WAIT_CYC    = (REFCLK_WAIT_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int          TRAIN_MAX_MS       = 80;
	localparam int          TRAIN_MAX_CYC      = TRAIN_MAX_MS * 200000;
	localparam int          TRAIN_DELAY_CYC    = 64;
	localparam int          CNT_W              = 24;
	localparam int          STRAP_W            = 8;
	localparam logic [7:0]  STRAP_RESET        = 8'h00;

	typedef enum logic [3:0] {
		BRC_POWER  = 4'b0001,
		BRC_CLKWT  = 4'b0010,
		BRC_RESET  = 4'b0100,
		BRC_RUN    = 4'b1000
	} brc_state_t;

	// Reset strobes for each register domain.
	typedef struct packed {
		logic sticky;
		logic eeprom;
		logic aux_pm;
		logic ordinary;
	} brc_domains_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} brc_cfg_req_t;
endpackage
`default_nettype wire

/* File: bench/brc_reset_chk.sv */
// Port assertions for the bridge reset controller.
`default_nettype none
module brc_reset_chk #(
	parameter int TRAIN_CYC = 64
) (
	input wire logic                  clk_sys_in,
	input wire logic                  rst_in,
	input wire logic                  global_reset_n_in,
	input wire logic                  fund_reset_n_in,
	input wire logic                  hot_reset_in,
	input wire brc_pkg::brc_cfg_req_t cfg_req_in,
	input wire logic                  secondary_bus_reset_n_out,
	input wire logic                  link_reset_out,
	input wire logic                  data_link_down_out,
	input wire logic                  power_good_out,
	input wire logic                  link_train_start_out,
	input wire brc_pkg::brc_domains_t domain_reset_out
);
	localparam int TRAIN_LIM = TRAIN_CYC + 16;
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	sequence s_sec_set;
		cfg_req_in.wr && cfg_req_in.addr == brc_pkg::SEC_BUS_CTL_OFFSET &&
			cfg_req_in.wdata[brc_pkg::SEC_RESET_BIT];
	endsequence
	sequence s_link_up;
		power_good_out && !data_link_down_out && !link_reset_out;
	endsequence
	a_global_reset_n_sec_reset: assert property (!global_reset_n_in |=> !secondary_bus_reset_n_out)
		else $error("secondary reset released during global reset");
	a_fund_sec_reset: assert property (!fund_reset_n_in [*5] |-> !secondary_bus_reset_n_out)
		else $error("secondary reset released during fundamental reset");
	a_fund_link_reset: assert property (!fund_reset_n_in [*5] |->
		link_reset_out && domain_reset_out.ordinary)
		else $error("link reset or ordinary domain reset missing");
	a_fund_power_good: assert property (!fund_reset_n_in [*5] |-> !power_good_out)
		else $error("power good set while fundamental reset low");
	a_hot_link_down: assert property (hot_reset_in [*5] |-> data_link_down_out)
		else $error("hot reset did not enter link down");
	a_down_domain_set: assert property ((data_link_down_out && power_good_out) [*2] |->
		domain_reset_out.ordinary && !domain_reset_out.sticky && !domain_reset_out.eeprom)
		else $error("wrong domains reset in link down");
	a_train_bound: assert property ($rose(power_good_out) |-> ##[0:TRAIN_LIM] link_train_start_out)
		else $error("link training did not start in time");
	a_sw_sec_set: assert property (s_sec_set ##0 s_link_up |-> ##2 !secondary_bus_reset_n_out)
		else $error("software bit did not assert secondary reset");
endmodule
bind brc_reset_ctrl brc_reset_chk #(.TRAIN_CYC(TRAIN_CYC)) u_chk (.clk_sys_in(clk_sys_in),
	.rst_in(rst_in), .global_reset_n_in(global_reset_n_in), .fund_reset_n_in(fund_reset_n_in),
	.hot_reset_in(hot_reset_in), .cfg_req_in(cfg_req_in),
	.secondary_bus_reset_n_out(secondary_bus_reset_n_out), .link_reset_out(link_reset_out),
	.data_link_down_out(data_link_down_out), .power_good_out(power_good_out),
	.link_train_start_out(link_train_start_out), .domain_reset_out(domain_reset_out));
`default_nettype wire

/* File: bench/brc_upstream_model.sv */
// Upstream port model driving fundamental reset, clock activity and hot reset.
`default_nettype none
module brc_upstream_model #(
	parameter int HOLD_CYC = 20000
) (
	input  wire logic clk_sys_in,
	input  wire logic power_on_in,
	input  wire logic fund_req_in,
	input  wire logic hot_req_in,
	output logic      refclk_active_out,
	output logic      fund_reset_n_out,
	output logic      hot_reset_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold;
	// When power is removed, clock activity stops one cycle after reset goes low, never before it.
	always_ff @(posedge clk_sys_in) begin
		refclk_active_out <= power_on_in | fund_reset_n_out;
		hot_reset_out <= hot_req_in;
		if (!power_on_in || fund_req_in) begin
			hold <= 0;
			fund_reset_n_out <= 1'b0;
		end else if (hold < HOLD_CYC) begin
			hold <= hold + 1;
		end else begin
			fund_reset_n_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the bridge reset controller.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk_sys_in = 1'b0;
	logic                  rst_in = 1'b1;
	logic                  global_reset_n_n = 1'b1;
	logic                  supply = 1'b0;
	logic                  power_on = 1'b0;
	logic                  fund_req = 1'b0;
	logic                  hot_req = 1'b0;
	logic [7:0]            strap = 8'h5a;
	brc_pkg::brc_cfg_req_t req = '0;
	logic                  refclk, fund_n, hot, sec_n, lrst, dld, pgood, ee, train;
	logic [15:0]           rdata;
	logic [7:0]            strap_q;
	brc_pkg::brc_domains_t dom;
	logic                  ee_present = 1'b1;
	int                    ee_count = 0;
	int                    err_count = 0;
	int                    checks_done = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	always @(negedge clk_sys_in) begin
		if (ee === 1'b1) begin
			ee_count++;
		end
	end
	brc_upstream_model u_host (.clk_sys_in(clk_sys_in), .power_on_in(power_on),
		.fund_req_in(fund_req), .hot_req_in(hot_req), .refclk_active_out(refclk),
		.fund_reset_n_out(fund_n), .hot_reset_out(hot));
	brc_reset_ctrl #(.TRAIN_CYC(8)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.global_reset_n_in(global_reset_n_n), .fund_reset_n_in(fund_n), .core_supply_sense_in(supply),
		.refclk_active_in(refclk), .hot_reset_in(hot), .eeprom_present_in(ee_present),
		.strap_in(strap), .cfg_req_in(req), .cfg_rdata_out(rdata),
		.secondary_bus_reset_n_out(sec_n), .link_reset_out(lrst), .data_link_down_out(dld),
		.power_good_out(pgood), .eeprom_load_start_out(ee), .link_train_start_out(train),
		.domain_reset_out(dom), .strap_out(strap_q));
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_pulse(input int sel, input int lim);
		for (int n = 0; n < lim; n++) begin
			@(negedge clk_sys_in);
			if ((sel == 0 ? ee : train) === 1'b1) return;
		end
		err_count++;
		$display("MISMATCH t=%0t wait expired", $time);
		tally_and_finish();
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk_sys_in);
		req = '0;
		repeat (2) @(negedge clk_sys_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk_sys_in);
		req = '0;
		@(negedge clk_sys_in);
		chk(rdata, exp);
	endtask
	initial begin
		repeat (10) @(negedge clk_sys_in);
		rst_in = 1'b0;
		supply = 1'b1;
		power_on = 1'b1;
		wait_pulse(0, 21000);
		chk(16'(pgood), 16'h0001);
		strap = 8'h33;
		wait_pulse(1, 16);
		chk({sec_n, 7'h00, strap_q}, 16'h805a);
		wr(brc_pkg::SEC_BUS_CTL_OFFSET, 16'h0a40);
		rd(brc_pkg::SEC_BUS_CTL_OFFSET, 16'h0a40);
		chk(16'(sec_n), 16'h0000);
		rd(8'h40, 16'h0000);
		wr(brc_pkg::SEC_BUS_CTL_OFFSET, 16'h0a00);
		chk(16'(sec_n), 16'h0001);
		hot_req = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		chk({sec_n, dld, dom.sticky, dom.eeprom, dom.ordinary}, 16'h0009);
		wr(brc_pkg::SEC_BUS_CTL_OFFSET, 16'h0040);
		hot_req = 1'b0;
		wait_pulse(1, 16);
		rd(brc_pkg::SEC_BUS_CTL_OFFSET, 16'h0000);
		fund_req = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		chk({sec_n, lrst, pgood, dom.sticky, dom.ordinary}, 16'h0009);
		strap = 8'hc3;
		fund_req = 1'b0;
		wait_pulse(0, 20400);
		chk({8'h00, strap_q}, 16'h00c3);
		wait_pulse(1, 16);
		global_reset_n_n = 1'b0;
		strap = 8'h96;
		ee_present = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		chk({sec_n, dom.sticky, dom.aux_pm, dom.ordinary}, 16'h0007);
		global_reset_n_n = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		strap = 8'h0f;
		wait_pulse(1, 5000);
		chk({8'h00, strap_q}, 16'h0096);
		chk(16'(ee_count), 16'h0002);
		tally_and_finish();
	end
endmodule
`default_nettype wire
